/* File: hdl/gpio_port_pkg.sv */
/*
  Constants, register map and carrier types for the eight-pin I/O port
  drive mode controller.
  Assumes a single 250 MHz clock and an AHB-Lite register bus of 32 bits.
*/
package gpio_port_pkg;

  // ==========================================================================
  // Port geometry
  localparam int PIN_COUNT = 8;
  localparam int MODE_WIDTH = 3;

  // ==========================================================================
  // Drive mode codes
  localparam logic [2:0] MODE_HIZ_ANALOG = 3'h0;
  localparam logic [2:0] MODE_HIZ_DIGITAL = 3'h1;
  localparam logic [2:0] MODE_RES_PULL_UP = 3'h2;
  localparam logic [2:0] MODE_RES_PULL_DOWN = 3'h3;
  localparam logic [2:0] MODE_OPEN_DRAIN_LOW = 3'h4;
  localparam logic [2:0] MODE_OPEN_DRAIN_HIGH = 3'h5;
  localparam logic [2:0] MODE_STRONG = 3'h6;
  localparam logic [2:0] MODE_RES_BOTH = 3'h7;

  // Edge type select codes, two bits per pin
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================================
  // Register byte offsets, port form
  localparam logic [7:0] OFS_OUT_DATA = 8'h00;
  localparam logic [7:0] OFS_MODE0 = 8'h04;
  localparam logic [7:0] OFS_MODE1 = 8'h08;
  localparam logic [7:0] OFS_MODE2 = 8'h0c;
  localparam logic [7:0] OFS_BYPASS = 8'h10;
  localparam logic [7:0] OFS_BIDIR = 8'h14;
  localparam logic [7:0] OFS_PIN_STATE = 8'h18;
  localparam logic [7:0] OFS_EDGE_TYPE = 8'h1c;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_REGULATED = 8'h28;
  // Pin form: one word per pin from this base, stride four bytes
  localparam logic [7:0] OFS_PIN_BASE = 8'h40;
  localparam logic [7:0] OFS_PIN_LAST = 8'h5c;

  // Pin form field positions
  localparam int PF_DATA = 0;
  localparam int PF_MODE_LSB = 1;
  localparam int PF_BYPASS = 4;
  localparam int PF_BIDIR = 5;
  localparam int PF_EDGE_LSB = 6;
  localparam int PF_REGULATED = 8;
  localparam int PF_STATE = 9;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_DRIVE_MODES = 24'h000000;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // ==========================================================================
  // Controls toward one pad
  typedef struct packed {
    logic strong_hi;  // Strong drive to high
    logic strong_lo;  // Strong drive to low
    logic pull_up;  // Resistive drive to high
    logic pull_down;  // Resistive drive to low
    logic in_en;  // Digital input buffer on
  } pad_ctl_t;

  // Decoded AHB address phase
  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } bus_req_t;

endpackage

/* File: hdl/pin_drive_decode.sv */
/*
  Drive mode decoder for one pin: maps mode, data and bidirectional
  control onto pad driver and input buffer controls.
  Assumes the caller registers the result before it reaches a pad.
*/
`timescale 1ns/100ps
module pin_drive_decode
  import gpio_port_pkg::*;
(
  input wire logic [2:0] i_mode,
  input wire logic i_data,
  input wire logic i_bidir_en,
  input wire logic i_route_oe,
  input wire logic i_regulated,
  output pad_ctl_t o_ctl
);

  // ==========================================================================
  // Mode decode
  always_comb
  begin
    logic [2:0] mode;
    mode = i_mode;
    // Bidir with output enable low falls back to digital high-Z
    if (i_bidir_en && !i_route_oe)
    begin
      mode = MODE_HIZ_DIGITAL;
    end
    o_ctl = '0;
    o_ctl.in_en = (mode != MODE_HIZ_ANALOG);
    unique case (mode)
      MODE_HIZ_ANALOG, MODE_HIZ_DIGITAL:
      begin
        o_ctl.in_en = (mode == MODE_HIZ_DIGITAL);
      end
      MODE_RES_PULL_UP:
      begin
        o_ctl.strong_lo = !i_data;
        o_ctl.pull_up = i_data;
      end
      MODE_RES_PULL_DOWN:
      begin
        o_ctl.strong_hi = i_data;
        o_ctl.pull_down = !i_data;
      end
      MODE_OPEN_DRAIN_LOW:
      begin
        o_ctl.strong_lo = !i_data;
      end
      MODE_OPEN_DRAIN_HIGH:
      begin
        o_ctl.strong_hi = i_data;
      end
      MODE_STRONG:
      begin
        // Input left on; reading a strongly driven pin only echoes the data
        o_ctl.strong_hi = i_data;
        o_ctl.strong_lo = !i_data;
      end
      MODE_RES_BOTH:
      begin
        o_ctl.pull_up = i_data;
        o_ctl.pull_down = !i_data;
      end
    endcase
    // Regulated level has no resistive legs; that data state floats
    if (i_regulated)
    begin
      o_ctl.pull_up = 1'b0;
      o_ctl.pull_down = 1'b0;
    end
  end

endmodule

/* File: hdl/pin_edge_detect.sv */
/*
  Pin input synchroniser and edge detector for a group of pins.
  Assumes raw pad inputs from outside the clock domain.
*/
`timescale 1ns/100ps
module pin_edge_detect
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_pin,
  input wire logic [WIDTH-1:0] i_in_en,
  input wire logic [2*WIDTH-1:0] i_edge_type,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_event
);

  logic [WIDTH-1:0] sync1_q;  // First stage, read only by second
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] sync3_q;
  logic [WIDTH-1:0] prev_q;  // Level one cycle earlier
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  // ==========================================================================
  // Three-stage synchroniser, change accepted when stages two and three agree
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      o_level <= '0;
    end
    else
    begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // Disabled input buffer gives no digital value
      for (int i = 0; i < WIDTH; i++)
      begin
        if (!i_in_en[i])
          o_level[i] <= 1'b0;
        else if (sync2_q[i] == sync3_q[i])
          o_level[i] <= sync3_q[i];
      end
    end
  end

  // ==========================================================================
  // Edge compare against previous cycle, one pulse per transition
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      prev_q <= '0;
    else
      prev_q <= o_level;
  end

  assign rise = o_level & ~prev_q;
  assign fall = ~o_level & prev_q;

  // Only edge kinds exist; no level sensing path
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      unique case (i_edge_type[2*i +: 2])
        EDGE_NONE: o_event[i] = 1'b0;
        EDGE_RISE: o_event[i] = rise[i];
        EDGE_FALL: o_event[i] = fall[i];
        EDGE_BOTH: o_event[i] = rise[i] | fall[i];
      endcase
    end
  end

endmodule

/* File: hdl/io_port_drive_mode_control.sv */
/*
  Eight-pin I/O port controller: register file on AHB-Lite, per-pin
  drive mode decode, routing bypass, bidirectional control, pin state
  read and edge interrupts with a single port interrupt line.
  Assumes one clock, a single AHB-Lite master with single word
  transfers, and an external pad cell that turns the registered
  controls into drive strengths.
*/
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module io_port_drive_mode_control
  import gpio_port_pkg::*;
#(
  parameter int PINS = PIN_COUNT,
  // Power-up drive modes, three bits per pin; analog high-Z by default
  parameter logic [3*PIN_COUNT-1:0] RESET_DRIVE_MODES = RST_DRIVE_MODES,
  // Power-up output data
  parameter logic [PIN_COUNT-1:0] RESET_OUT_DATA = RST_BYTE
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  // Internal digital routing
  input wire logic [PINS-1:0] i_route_data,
  input wire logic [PINS-1:0] i_route_oe,
  output logic [PINS-1:0] o_route_in,
  // Pads
  input wire logic [PINS-1:0] i_pad_in,
  output logic [PINS-1:0] o_pad_out,
  output logic [PINS-1:0] o_pad_oe_n,
  output logic [PINS-1:0] o_pad_pull_up,
  output logic [PINS-1:0] o_pad_pull_down,
  output logic [PINS-1:0] o_pad_in_en,
  // Port interrupt
  output logic o_irq
);

  // ==========================================================================
  // Storage
  logic [PINS-1:0] out_data_q;  // Port output data
  logic [PINS-1:0] mode0_q;  // Drive mode bit planes
  logic [PINS-1:0] mode1_q;
  logic [PINS-1:0] mode2_q;
  logic [PINS-1:0] bypass_q;  // Routing bypass select
  logic [PINS-1:0] bidir_q;  // Bidirectional enable
  logic [2*PINS-1:0] edge_type_q;  // Edge type select
  logic [PINS-1:0] flags_q;  // Sticky pin event flags
  logic [PINS-1:0] mask_q;  // Interrupt mask
  logic [PINS-1:0] regulated_q;  // Regulated output level select

  // Bus pipeline
  bus_req_t req_q;  // Captured address phase
  logic wr_pend_q;  // Write data phase this cycle
  logic rd_late_q;  // Read delayed behind a write
  bus_req_t req_now;
  logic accept;

  // Pin side
  logic [PINS-1:0] pin_level;  // Synchronised pin state
  logic [PINS-1:0] pin_event;  // One-cycle edge events
  pad_ctl_t ctl [PINS];
  logic [PINS-1:0] drive_data;
  logic [PINS-1:0] clr_flags;

  // ==========================================================================
  // Helpers

  // Pin form word index, or all ones when the address is not pin form
  function automatic logic [3:0] pin_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - OFS_PIN_BASE;
    if (addr >= OFS_PIN_BASE && addr <= OFS_PIN_LAST)
      pin_index = {1'b0, rel[4:2]};
    else
      pin_index = 4'hf;
  endfunction

  // Read mux across port form and pin form
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [3:0] idx;
    logic [2:0] p;
    idx = pin_index(addr);
    p = idx[2:0];
    read_word = '0;
    if (!idx[3])
    begin
      // Pin form view of the same storage
      read_word[PF_DATA] = out_data_q[p];
      read_word[PF_MODE_LSB +: 3] = {mode2_q[p], mode1_q[p], mode0_q[p]};
      read_word[PF_BYPASS] = bypass_q[p];
      read_word[PF_BIDIR] = bidir_q[p];
      read_word[PF_EDGE_LSB +: 2] = edge_type_q[2*p +: 2];
      read_word[PF_REGULATED] = regulated_q[p];
      read_word[PF_STATE] = pin_level[p];
    end
    else
    begin
      unique case (addr)
        OFS_OUT_DATA: read_word[PINS-1:0] = out_data_q;
        OFS_MODE0: read_word[PINS-1:0] = mode0_q;
        OFS_MODE1: read_word[PINS-1:0] = mode1_q;
        OFS_MODE2: read_word[PINS-1:0] = mode2_q;
        OFS_BYPASS: read_word[PINS-1:0] = bypass_q;
        OFS_BIDIR: read_word[PINS-1:0] = bidir_q;
        OFS_PIN_STATE: read_word[PINS-1:0] = pin_level;
        OFS_EDGE_TYPE: read_word[2*PINS-1:0] = edge_type_q;
        OFS_EVENT_FLAGS: read_word[PINS-1:0] = flags_q;
        OFS_IRQ_MASK: read_word[PINS-1:0] = mask_q;
        OFS_REGULATED: read_word[PINS-1:0] = regulated_q;
        // Unmapped addresses read as zero
        default: read_word = '0;
      endcase
    end
  endfunction

  // Write strobe for a port form offset
  function automatic logic port_wr(input logic [7:0] ofs);
    port_wr = wr_pend_q && req_q.addr == ofs;
  endfunction

  // ==========================================================================
  // AHB-Lite address phase
  assign accept = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  assign req_now.write = i_hwrite;
  assign req_now.addr = {i_haddr[7:2], 2'b00};

  // Capture address phase, flag write data phase
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      req_q <= '0;
      wr_pend_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= accept && i_hwrite;
      if (accept)
        req_q <= req_now;
    end
  end

  // Read data and ready; a read right after a write waits one cycle so it
  // sees the written value instead of stale storage
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_hrdata <= '0;
      o_hreadyout <= 1'b1;
      rd_late_q <= 1'b0;
    end
    else if (rd_late_q)
    begin
      o_hrdata <= read_word(req_q.addr);
      o_hreadyout <= 1'b1;
      rd_late_q <= 1'b0;
    end
    else if (accept && !i_hwrite && wr_pend_q)
    begin
      o_hreadyout <= 1'b0;
      rd_late_q <= 1'b1;
    end
    else if (accept && !i_hwrite)
    begin
      o_hrdata <= read_word(req_now.addr);
    end
  end

  // Every response is OKAY
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_hresp <= HRESP_OKAY;
    else
      o_hresp <= HRESP_OKAY;
  end

  // ==========================================================================
  // Configuration registers, written in port form or pin form
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    logic [3:0] idx;
    if (i_reset)
    begin
      // Drive modes come up from the user chosen parameter
      for (int i = 0; i < PINS; i++)
      begin
        mode0_q[i] <= RESET_DRIVE_MODES[3*i];
        mode1_q[i] <= RESET_DRIVE_MODES[3*i+1];
        mode2_q[i] <= RESET_DRIVE_MODES[3*i+2];
      end
      out_data_q <= RESET_OUT_DATA;
      bypass_q <= '0;
      bidir_q <= '0;
      edge_type_q <= '0;
      mask_q <= '0;
      regulated_q <= '0;
    end
    else
    begin
      idx = pin_index(req_q.addr);
      // Port form: one bit per pin, two per pin for edge type
      if (port_wr(OFS_OUT_DATA))
        out_data_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_MODE0))
        mode0_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_MODE1))
        mode1_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_MODE2))
        mode2_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_BYPASS))
        bypass_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_BIDIR))
        bidir_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_EDGE_TYPE))
        edge_type_q <= i_hwdata[2*PINS-1:0];
      if (port_wr(OFS_IRQ_MASK))
        mask_q <= i_hwdata[PINS-1:0];
      if (port_wr(OFS_REGULATED))
        regulated_q <= i_hwdata[PINS-1:0];
      // Pin form: all fields of one pin in a single write
      if (wr_pend_q && !idx[3])
      begin
        out_data_q[idx[2:0]] <= i_hwdata[PF_DATA];
        mode0_q[idx[2:0]] <= i_hwdata[PF_MODE_LSB];
        mode1_q[idx[2:0]] <= i_hwdata[PF_MODE_LSB+1];
        mode2_q[idx[2:0]] <= i_hwdata[PF_MODE_LSB+2];
        bypass_q[idx[2:0]] <= i_hwdata[PF_BYPASS];
        bidir_q[idx[2:0]] <= i_hwdata[PF_BIDIR];
        edge_type_q[2*idx[2:0] +: 2] <= i_hwdata[PF_EDGE_LSB +: 2];
        regulated_q[idx[2:0]] <= i_hwdata[PF_REGULATED];
      end
    end
  end

  // ==========================================================================
  // Output data source per pin
  assign drive_data = (bypass_q & i_route_data) | (~bypass_q & out_data_q);

  // ==========================================================================
  // Per-pin drive decode
  for (genvar g = 0; g < PINS; g++)
  begin : g_pin
    pin_drive_decode u_decode (
      .i_mode({mode2_q[g], mode1_q[g], mode0_q[g]}),
      .i_data(drive_data[g]),
      .i_bidir_en(bidir_q[g]),
      .i_route_oe(i_route_oe[g]),
      .i_regulated(regulated_q[g]),
      .o_ctl(ctl[g])
    );
  end

  // Registered pad controls; pads come up analog high-Z, nothing driven
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_pad_out <= '0;
      o_pad_oe_n <= '1;
      o_pad_pull_up <= '0;
      o_pad_pull_down <= '0;
      o_pad_in_en <= '0;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        // Strong value and active-low strong enable
        o_pad_out[i] <= ctl[i].strong_hi;
        o_pad_oe_n[i] <= !(ctl[i].strong_hi || ctl[i].strong_lo);
        o_pad_pull_up[i] <= ctl[i].pull_up;
        o_pad_pull_down[i] <= ctl[i].pull_down;
        o_pad_in_en[i] <= ctl[i].in_en;
      end
    end
  end

  // ==========================================================================
  // Input path and edge detection
  pin_edge_detect #(
    .WIDTH(PINS)
  ) u_edges (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_pad_in),
    .i_in_en(o_pad_in_en),
    .i_edge_type(edge_type_q),
    .o_level(pin_level),
    .o_event(pin_event)
  );

  // Synchronised pin state toward internal logic
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_route_in <= '0;
    else
      o_route_in <= pin_level;
  end

  // ==========================================================================
  // Sticky event flags, write one to clear; a new event beats the clear
  assign clr_flags = port_wr(OFS_EVENT_FLAGS) ? i_hwdata[PINS-1:0] : '0;

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      flags_q <= '0;
    else
      flags_q <= (flags_q & ~clr_flags) | pin_event;
  end

  // Single port request line, level, high while an unmasked flag stands
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= |(((flags_q & ~clr_flags) | pin_event) & mask_q);
  end

endmodule

/* File: test/port_checker.sv */
/*
  Port assertions for the I/O port controller.
  Assumes the bind below and one clock with an async high reset.
*/
`timescale 1ns/100ps
module port_checker
  import gpio_port_pkg::*;
#(
  parameter int PINS = 8
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp,
  input wire logic [PINS-1:0] o_pad_oe_n,
  input wire logic [PINS-1:0] o_pad_pull_up,
  input wire logic [PINS-1:0] o_pad_pull_down,
  input wire logic [PINS-1:0] o_pad_in_en,
  input wire logic o_irq
);
  // ==========
  // Helpers
  logic taken;  // Address phase accepted
  logic [3:0] wr_hist_q;  // Writes seen in the last four cycles
  assign taken = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  // Shift in accepted writes; an irq may only drop after one
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      wr_hist_q <= 4'h0;
    else
      wr_hist_q <= {wr_hist_q[2:0], taken && i_hwrite};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========
  // Assertions
  chk_resp_okay: assert property (o_hresp == HRESP_OKAY)
    else $error("bus response not okay");
  chk_strong_no_pull: assert property (
    (~o_pad_oe_n & (o_pad_pull_up | o_pad_pull_down)) == '0)
    else $error("strong and resistive drive together");
  chk_pull_excl: assert property ((o_pad_pull_up & o_pad_pull_down) == '0)
    else $error("pull up and pull down together");
  chk_drive_input: assert property (
    ((~o_pad_oe_n | o_pad_pull_up | o_pad_pull_down) & ~o_pad_in_en) == '0)
    else $error("driving pin with input buffer off");
  chk_reset_pads: assert property ($fell(i_reset) |->
    &o_pad_oe_n && o_pad_in_en == '0 && !o_irq && o_hreadyout)
    else $error("pads not idle at reset release");
  chk_wait_one: assert property (!o_hreadyout |=> o_hreadyout)
    else $error("wait state longer than one cycle");
  chk_rdata_hold: assert property (
    (!(taken && !i_hwrite) ##1 !(taken && !i_hwrite)) |=> $stable(o_hrdata))
    else $error("read data moved without a read");
  chk_irq_sticky: assert property ($fell(o_irq) |-> |wr_hist_q)
    else $error("irq dropped without a write");
endmodule

bind io_port_drive_mode_control port_checker #(.PINS(PINS)) u_port_checker (
  .i_clk, .i_reset, .i_hsel, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout,
  .o_hrdata, .o_hresp, .o_pad_oe_n, .o_pad_pull_up, .o_pad_pull_down,
  .o_pad_in_en, .o_irq
);

/* File: test/board_pins.sv */
/*
  Board side of the eight port pins: resolves each pin level.
  Assumes pad controls straight from the controller's outputs.
*/
`timescale 1ns/100ps
module board_pins
(
  input wire logic i_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_pull_up,
  input wire logic [7:0] i_pull_down,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  output logic [7:0] o_level
);
  logic [7:0] last_q = 8'h00;  // Previous levels, for floating pins
  always_ff @(posedge i_clk)
    last_q <= o_level;
  // Strong drive wins, then the board, then the resistors
  always_comb
  begin
    for (int b = 0; b < 8; b++)
    begin
      if (!i_oe_n[b])
        o_level[b] = i_out[b];
      else if (i_ext_en[b])
        o_level[b] = i_ext_val[b];
      else if (i_pull_up[b])
        o_level[b] = 1'b1;
      else if (i_pull_down[b])
        o_level[b] = 1'b0;
      else
        o_level[b] = ~last_q[b];  // Floating: never a steady guess
    end
  end
endmodule

/* File: test/test_io_port_drive_mode_control.sv */
/*
  Self-checking bench for the I/O port controller.
  Assumes the package, design, checker and board model compiled first.
*/
`timescale 1ns/100ps
module test_io_port_drive_mode_control;
  import gpio_port_pkg::*;
  // ==========
  // Signals
  logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic hready, hresp, irq;
  logic [7:0] route_data = 8'h00, route_oe = 8'h00, ext_en = 8'hff, ext_val = 8'h00;
  logic [7:0] route_in, pad_in, pad_out, oe_n, pu, pd, ie;
  int error_cnt = 0, checks_done = 0;
  // {strong hi, strong lo, pull up, pull down, input on} by mode*2+data
  logic [4:0] exp_tbl [16] = '{5'h00, 5'h00, 5'h01, 5'h01, 5'h09, 5'h05, 5'h03, 5'h11,
    5'h09, 5'h01, 5'h01, 5'h11, 5'h09, 5'h11, 5'h03, 5'h05};
  // Pin 0 rows: pin form word, {route data, route oe}, expected controls
  logic [11:0] sp_word [6] = '{12'h01c, 12'h01c, 12'h02d, 12'h02d, 12'h105, 12'h104};
  logic [1:0] sp_route [6] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
  logic [4:0] sp_exp [6] = '{5'h11, 5'h09, 5'h01, 5'h11, 5'h01, 5'h09};
  always #2 clk = ~clk;
  // Pin 7 powers up strong high, the rest analog high-Z
  io_port_drive_mode_control #(.RESET_DRIVE_MODES(24'hc00000), .RESET_OUT_DATA(8'h80))
    u_io_port_drive_mode_control (.i_clk(clk), .i_reset(reset), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata),
    .o_hresp(hresp), .i_route_data(route_data), .i_route_oe(route_oe),
    .o_route_in(route_in), .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe_n(oe_n),
    .o_pad_pull_up(pu), .o_pad_pull_down(pd), .o_pad_in_en(ie), .o_irq(irq));
  board_pins u_board_pins (.i_clk(clk), .i_out(pad_out), .i_oe_n(oe_n), .i_pull_up(pu),
    .i_pull_down(pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pad_in));
  // ==========
  // Tasks
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Next edge with ready sampled high; the watchdog bounds it
  task automatic ready;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    ready();
    r = hrdata;
  endtask
  // Write then read the same place back to back, forcing the wait state
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    ready();
    hwrite <= 1'b0;
    hwdata <= d;
    ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    ready();
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk((r & m) === e, "read data");
  endtask
  task automatic pads(input int p, input logic [4:0] e);
    chk({!oe_n[p] && pad_out[p], !oe_n[p] && !pad_out[p], pu[p], pd[p], ie[p]} === e,
      "pad controls");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Watchdog: the sequence needs a few hundred cycles
  initial
  begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout", $time);
    summarize();
  end
  // ==========
  // Sequence
  initial
  begin
    tick(2);
    reset <= 1'b0;
    tick(3);
    for (int p = 0; p < 7; p++) pads(p, 5'h00);
    pads(7, 5'h11);
    rd(OFS_OUT_DATA, 32'h80, 32'hffffffff);
    $display("test reset done");
    // Every mode with both data values, spread over the pins
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b1, OFS_PIN_BASE + 8'(4 * (i % 8)), 32'(i));
      tick(3);
      pads(i % 8, exp_tbl[i]);
    end
    for (int p = 0; p < 8; p++) pads(p, exp_tbl[p + 8]);
    rd(OFS_MODE0, 32'hcc, 32'hffffffff);
    rd(OFS_MODE1, 32'hf0, 32'hffffffff);
    rd(OFS_MODE2, 32'hff, 32'hffffffff);
    bus(1'b1, OFS_MODE1, 32'h0);
    rd(OFS_PIN_BASE + 8'h18, 32'ha, 32'hfffffdff);
    $display("test drive modes done");
    // All pins as digital inputs driven by the board
    bus(1'b1, OFS_MODE0, 32'hff);
    bus(1'b1, OFS_MODE2, 32'h0);
    ext_val <= 8'h5a;
    tick(8);
    wr_rd(OFS_OUT_DATA, 32'h3c);
    chk(r === 32'h3c, "output data");
    bus(1'b1, OFS_PIN_STATE, 32'hff);
    rd(OFS_PIN_STATE, 32'h5a, 32'hffffffff);
    chk(route_in === 8'h5a, "routed input");
    $display("test pin state done");
    for (int i = 0; i < 6; i++)
    begin
      route_data[0] <= sp_route[i][1];
      route_oe[0] <= sp_route[i][0];
      bus(1'b1, OFS_PIN_BASE, {20'h0, sp_word[i]});
      tick(3);
      pads(0, sp_exp[i]);
    end
    $display("test routing done");
    // Pin 1 through every edge type
    bus(1'b1, OFS_IRQ_MASK, 32'h2);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, OFS_EDGE_TYPE, 32'(c) << 2);
      ext_val[1] <= 1'b0;
      tick(8);
      bus(1'b1, OFS_EVENT_FLAGS, 32'hff);
      ext_val[1] <= 1'b1;
      tick(8);
      rd(OFS_EVENT_FLAGS, 32'(c & 1) << 1, 32'hffffffff);
      chk(irq === c[0], "irq on rise");
      bus(1'b1, OFS_EVENT_FLAGS, 32'h2);
      tick(8);
      rd(OFS_EVENT_FLAGS, 32'h0, 32'hffffffff);
      ext_val[1] <= 1'b0;
      tick(8);
      rd(OFS_EVENT_FLAGS, 32'((c >> 1) & 1) << 1, 32'hffffffff);
    end
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    tick(2);
    chk(irq === 1'b0, "masked irq");
    bus(1'b1, OFS_IRQ_MASK, 32'h2);
    tick(2);
    chk(irq === 1'b1, "unmasked irq");
    bus(1'b1, OFS_EVENT_FLAGS, 32'h2);
    tick(2);
    chk(irq === 1'b0, "cleared irq");
    $display("test interrupts done");
    summarize();
  end
endmodule
